// ---- rtl/rxlos_cmp.v ----
`timescale 1ns/100ps
`include "rxlos_map.vh"

module rxlos_cmp
#(
  parameter CODE_W = 8
)
(
  input  wire [CODE_W-1:0] sample,
  input  wire [CODE_W-1:0] threshold,
  input  wire [2:0]        range_code,
  output wire              below,
  output wire              above
);

  function [13:0] full_scale_pct;
    input [2:0] code;
    begin
      case (code)
        3'h0:    full_scale_pct = `RXLOS_PCT_0;
        3'h1:    full_scale_pct = `RXLOS_PCT_1;
        3'h2:    full_scale_pct = `RXLOS_PCT_2;
        3'h3:    full_scale_pct = `RXLOS_PCT_3;
        3'h4:    full_scale_pct = `RXLOS_PCT_4;
        3'h5:    full_scale_pct = `RXLOS_PCT_5;
        3'h6:    full_scale_pct = `RXLOS_PCT_6;
        default: full_scale_pct = `RXLOS_PCT_7;
      endcase
    end
  endfunction

  // Sample scaled by 10000 and threshold by the range's full-scale percentage, so no division is needed
  wire [CODE_W+13:0] sample_scaled;
  wire [CODE_W+13:0] level_scaled;

  assign sample_scaled = sample * `RXLOS_PCT_FULL;
  assign level_scaled  = threshold * full_scale_pct(range_code);
  assign below         = sample_scaled < level_scaled;
  assign above         = sample_scaled > level_scaled;

endmodule

// ---- rtl/rxlos_map.vh ----
`ifndef RXLOS_MAP_VH
`define RXLOS_MAP_VH

// Register indices; byte address is four times the index
`define RXLOS_IDX_RANGE       8'hB8
`define RXLOS_IDX_GAP         8'hB9
`define RXLOS_IDX_HIGH_THR    8'hBA
`define RXLOS_IDX_LOW_THR     8'hBB

// Block-local registers, above the two mirrored pages
`define RXLOS_ADDR_PW_ENTRY   12'h800
`define RXLOS_ADDR_PW_LOWER   12'h804
`define RXLOS_ADDR_PW_HIGHER  12'h808
`define RXLOS_ADDR_CONTROL    12'h80C
`define RXLOS_ADDR_STATUS     12'h810

// Address fields
`define RXLOS_ADDR_OWN_BIT    11
`define RXLOS_ADDR_PAGE_BIT   10
`define RXLOS_ADDR_IDX_MSB    9
`define RXLOS_ADDR_IDX_LSB    2

// Range select fields
`define RXLOS_RANGE_HI_MSB    6
`define RXLOS_RANGE_HI_LSB    4
`define RXLOS_RANGE_LO_MSB    2
`define RXLOS_RANGE_LO_LSB    0
`define RXLOS_RANGE_WMASK     8'h77

// Control fields
`define RXLOS_CTRL_QT_EN      0
`define RXLOS_CTRL_RW_PERMIT  1
`define RXLOS_CTRL_RO_PERMIT  2

// Status fields
`define RXLOS_STAT_LOW_FLAG   0
`define RXLOS_STAT_HIGH_FLAG  1
`define RXLOS_STAT_LOWER_LVL  2
`define RXLOS_STAT_HIGHER_LVL 3
`define RXLOS_STAT_RSSI_LSB   8

// Reset values
`define RXLOS_RST_RANGE       8'h00
`define RXLOS_RST_THR         8'h00
`define RXLOS_RST_PASSWORD    32'hFFFFFFFF
`define RXLOS_RST_CONTROL     3'h0

// Full scale in hundredths of a percent of 1.25 V, per range code
`define RXLOS_PCT_0           14'd10000
`define RXLOS_PCT_1           14'd8002
`define RXLOS_PCT_2           14'd6669
`define RXLOS_PCT_3           14'd5005
`define RXLOS_PCT_4           14'd4005
`define RXLOS_PCT_5           14'd3338
`define RXLOS_PCT_6           14'd2862
`define RXLOS_PCT_7           14'd2504
`define RXLOS_PCT_FULL        14'd10000

`endif

// ---- rtl/rxlos_top.v ----
`timescale 1ns/100ps
`include "rxlos_map.vh"

module rxlos_top
#(
  parameter ADDR_W = 12,
  parameter CODE_W = 8
)
(
  input  wire              clock,
  input  wire              rst_n,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [ADDR_W-1:0] paddr,
  input  wire [31:0]       pwdata,
  output wire [31:0]       prdata,
  output wire              pready,
  output wire              pslverr,
  input  wire [CODE_W-1:0] rx2_signal_strength,
  output wire              rx2_signal_lost_low_flag,
  output wire              rx2_signal_present_high_flag,
  output wire              rx2_quick_trip_enable
);

  // Strength code crosses from the converter domain
  reg  [CODE_W-1:0] strength_meta_reg;
  reg  [CODE_W-1:0] strength_sync_reg;
  reg  [CODE_W-1:0] strength_prev_reg;
  reg  [CODE_W-1:0] strength_stable_reg;

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strength_meta_reg   <= {CODE_W{1'b0}};
      strength_sync_reg   <= {CODE_W{1'b0}};
      strength_prev_reg   <= {CODE_W{1'b0}};
      strength_stable_reg <= {CODE_W{1'b0}};
    end
    else
    begin
      strength_meta_reg <= rx2_signal_strength;
      strength_sync_reg <= strength_meta_reg;
      strength_prev_reg <= strength_sync_reg;
      // Bits of a moving code resync on different edges; a code is only
      // trusted once two synced samples agree
      if (strength_sync_reg == strength_prev_reg)
      begin
        strength_stable_reg <= strength_sync_reg;
      end
    end
  end

  // Register storage
  reg  [7:0]        range_reg;
  reg  [7:0]        high_thr_reg;
  reg  [7:0]        low_thr_reg;
  reg  [31:0]       pw_entry_reg;
  reg  [31:0]       pw_lower_reg;
  reg  [31:0]       pw_higher_reg;
  reg  [2:0]        control_reg;
  reg               lower_level_reg;
  reg               higher_level_reg;
  reg               low_flag_reg;
  reg               high_flag_reg;

  // Bus answer flops and their combinational next values
  reg  [31:0]       prdata_reg;
  reg  [31:0]       prdata_next;
  reg               pready_reg;
  reg               pslverr_reg;
  reg               pslverr_next;

  // Page bit is ignored here so both pages hit the same copy
  function idx_hit;
    input [ADDR_W-1:0] addr;
    input [7:0]        idx;
    begin
      idx_hit = !addr[`RXLOS_ADDR_OWN_BIT] &&
                (addr[`RXLOS_ADDR_IDX_MSB:`RXLOS_ADDR_IDX_LSB] == idx) &&
                (addr[1:0] == 2'b00);
    end
  endfunction

  function own_hit;
    input [ADDR_W-1:0] addr;
    input [11:0]       target;
    begin
      own_hit = (addr == target[ADDR_W-1:0]);
    end
  endfunction

  wire hit_range;
  wire hit_gap;
  wire hit_high;
  wire hit_low;
  wire hit_entry;
  wire hit_pw_lower;
  wire hit_pw_higher;
  wire hit_control;
  wire hit_status;
  wire hit_any;

  assign hit_range     = idx_hit(paddr, `RXLOS_IDX_RANGE);
  assign hit_gap       = idx_hit(paddr, `RXLOS_IDX_GAP);
  assign hit_high      = idx_hit(paddr, `RXLOS_IDX_HIGH_THR);
  assign hit_low       = idx_hit(paddr, `RXLOS_IDX_LOW_THR);
  assign hit_entry     = own_hit(paddr, `RXLOS_ADDR_PW_ENTRY);
  assign hit_pw_lower  = own_hit(paddr, `RXLOS_ADDR_PW_LOWER);
  assign hit_pw_higher = own_hit(paddr, `RXLOS_ADDR_PW_HIGHER);
  assign hit_control   = own_hit(paddr, `RXLOS_ADDR_CONTROL);
  assign hit_status    = own_hit(paddr, `RXLOS_ADDR_STATUS);
  assign hit_any       = hit_range | hit_gap | hit_high | hit_low |
                         hit_entry | hit_pw_lower | hit_pw_higher |
                         hit_control | hit_status;

  // Access levels
  wire rw_permit;
  wire ro_permit;
  wire qt_enable;
  wire read_ok;
  wire write_ok;
  wire thr_write_ok;

  assign rw_permit    = control_reg[`RXLOS_CTRL_RW_PERMIT];
  assign ro_permit    = control_reg[`RXLOS_CTRL_RO_PERMIT];
  assign qt_enable    = control_reg[`RXLOS_CTRL_QT_EN];
  assign read_ok      = higher_level_reg |
                        (lower_level_reg & (rw_permit | ro_permit));
  assign write_ok     = higher_level_reg |
                        (lower_level_reg & rw_permit);
  // Moving a threshold under a live comparator could glitch the alarm
  assign thr_write_ok = write_ok & ~qt_enable;

  // The access completes at the edge where pready is sampled high
  wire access_done;
  wire wr_done;

  assign access_done = psel & penable & pready_reg;
  assign wr_done     = access_done & pwrite;

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      range_reg    <= `RXLOS_RST_RANGE;
      high_thr_reg <= `RXLOS_RST_THR;
      low_thr_reg  <= `RXLOS_RST_THR;
    end
    else if (wr_done)
    begin
      if (hit_range && write_ok)
      begin
        range_reg <= pwdata[7:0] & `RXLOS_RANGE_WMASK;
      end
      if (hit_high && thr_write_ok)
      begin
        high_thr_reg <= pwdata[7:0];
      end
      if (hit_low && thr_write_ok)
      begin
        low_thr_reg <= pwdata[7:0];
      end
    end
  end

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pw_entry_reg  <= `RXLOS_RST_PASSWORD;
      pw_lower_reg  <= `RXLOS_RST_PASSWORD;
      pw_higher_reg <= `RXLOS_RST_PASSWORD;
      control_reg   <= `RXLOS_RST_CONTROL;
    end
    else if (wr_done)
    begin
      // Entry is always writable, or a locked host could never unlock
      if (hit_entry)
      begin
        pw_entry_reg <= pwdata;
      end
      if (hit_pw_lower && higher_level_reg)
      begin
        pw_lower_reg <= pwdata;
      end
      if (hit_pw_higher && higher_level_reg)
      begin
        pw_higher_reg <= pwdata;
      end
      if (hit_control && higher_level_reg)
      begin
        control_reg <= pwdata[2:0];
      end
    end
  end

  // Levels are registered, so they follow an entry write one edge late
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lower_level_reg  <= 1'b0;
      higher_level_reg <= 1'b0;
    end
    else
    begin
      lower_level_reg  <= (pw_entry_reg == pw_lower_reg);
      higher_level_reg <= (pw_entry_reg == pw_higher_reg);
    end
  end

  // Read data; denied reads and the reserved gap return zero
  always @*
  begin
    prdata_next  = 32'h00000000;
    pslverr_next = ~hit_any;
    if (hit_range && read_ok)
    begin
      prdata_next[7:0] = range_reg & `RXLOS_RANGE_WMASK;
    end
    if (hit_high && read_ok)
    begin
      prdata_next[7:0] = high_thr_reg;
    end
    if (hit_low && read_ok)
    begin
      prdata_next[7:0] = low_thr_reg;
    end
    if (hit_gap)
    begin
      prdata_next = 32'h00000000;
    end
    if (hit_control)
    begin
      prdata_next[2:0] = control_reg;
    end
    if (hit_status)
    begin
      prdata_next[`RXLOS_STAT_LOW_FLAG]    = low_flag_reg;
      prdata_next[`RXLOS_STAT_HIGH_FLAG]   = high_flag_reg;
      prdata_next[`RXLOS_STAT_LOWER_LVL]   = lower_level_reg;
      prdata_next[`RXLOS_STAT_HIGHER_LVL]  = higher_level_reg;
      prdata_next[`RXLOS_STAT_RSSI_LSB+CODE_W-1:`RXLOS_STAT_RSSI_LSB] =
        strength_stable_reg;
    end
  end

  // One wait state: pready rises in the second access cycle
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h00000000;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      pready_reg <= psel & penable & ~pready_reg;
      if (psel && penable && !pready_reg)
      begin
        pslverr_reg <= pslverr_next;
        prdata_reg  <= pwrite ? 32'h00000000 : prdata_next;
      end
      else
      begin
        pslverr_reg <= 1'b0;
        prdata_reg  <= 32'h00000000;
      end
    end
  end

  // Threshold comparisons
  wire below_low;
  wire above_high;

  rxlos_cmp
  #(
    .CODE_W     (CODE_W)
  )
  u_low_cmp
  (
    .sample     (strength_stable_reg),
    .threshold  (low_thr_reg),
    .range_code (range_reg[`RXLOS_RANGE_LO_MSB:`RXLOS_RANGE_LO_LSB]),
    .below      (below_low),
    .above      ()
  );

  rxlos_cmp
  #(
    .CODE_W     (CODE_W)
  )
  u_high_cmp
  (
    .sample     (strength_stable_reg),
    .threshold  (high_thr_reg),
    .range_code (range_reg[`RXLOS_RANGE_HI_MSB:`RXLOS_RANGE_HI_LSB]),
    .below      (),
    .above      (above_high)
  );

  // Loss wins if crossed thresholds make both conditions true
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      low_flag_reg  <= 1'b0;
      high_flag_reg <= 1'b0;
    end
    else if (below_low)
    begin
      low_flag_reg  <= 1'b1;
      high_flag_reg <= 1'b0;
    end
    else if (above_high)
    begin
      low_flag_reg  <= 1'b0;
      high_flag_reg <= 1'b1;
    end
  end

  assign prdata                       = prdata_reg;
  assign pready                       = pready_reg;
  assign pslverr                      = pslverr_reg;
  assign rx2_signal_lost_low_flag     = low_flag_reg;
  assign rx2_signal_present_high_flag = high_flag_reg;
  assign rx2_quick_trip_enable        = control_reg[`RXLOS_CTRL_QT_EN];

endmodule

// ---- verif/rxlos_checker.sv ----
`timescale 1ns/100ps
module rxlos_checker
#(
  parameter ADDR_W = 12,
  parameter CODE_W = 8
)
(
  input wire              clock,
  input wire              rst_n,
  input wire              psel,
  input wire              penable,
  input wire              pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0]       pwdata,
  input wire [31:0]       prdata,
  input wire              pready,
  input wire              pslverr,
  input wire [CODE_W-1:0] rx2_signal_strength,
  input wire              rx2_signal_lost_low_flag,
  input wire              rx2_signal_present_high_flag,
  input wire              rx2_quick_trip_enable
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire rd = pready && !pwrite && !paddr[11];
  reg  ctl_wr;
  always @(posedge clock or negedge rst_n)
    if (!rst_n)
      ctl_wr <= 1'b0;
    else
      ctl_wr <= pready && pwrite && paddr == 12'h80C && pwdata[0];
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    !pready ##1 pready;
  endsequence
  a_ready_wait: assert property (s_setup |=> s_answer)
    else $error("answer not two cycles after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_ready_qual: assert property (pready |-> psel && penable)
    else $error("ready outside an access");
  a_err_ready: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error without ready or with data");
  a_idle_zero: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  a_range_mask: assert property (rd && paddr[9:2] == 8'hB8 |->
    prdata[31:8] == 24'h0 && !prdata[7] && !prdata[3])
    else $error("reserved range bits not zero");
  a_gap_zero: assert property (rd && paddr[9:2] == 8'hB9 |-> prdata == 0)
    else $error("gap location not zero");
  a_flag_excl: assert property (!(rx2_signal_lost_low_flag
    && rx2_signal_present_high_flag))
    else $error("both alarm flags set");
  a_qt_cause: assert property ($rose(rx2_quick_trip_enable) |-> ctl_wr)
    else $error("quick trip enable rose without a write");
endmodule

bind rxlos_top rxlos_checker #(.ADDR_W(ADDR_W), .CODE_W(CODE_W)) u_chk (
  .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr),
  .rx2_signal_strength(rx2_signal_strength),
  .rx2_signal_lost_low_flag(rx2_signal_lost_low_flag),
  .rx2_signal_present_high_flag(rx2_signal_present_high_flag),
  .rx2_quick_trip_enable(rx2_quick_trip_enable));

// ---- verif/rxlos_host.sv ----
`timescale 1ns/100ps
module rxlos_host
(
  input  wire         clock,
  input  wire         pready,
  output logic        psel,
  output logic        penable,
  output logic        pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  // Leaves one idle edge before each setup, so no signal is assigned twice
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// ---- verif/rxlos_top_tb.sv ----
`timescale 1ns/100ps
module rxlos_top_tb;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  strength = 8'h00;
  wire         psel, penable, pwrite, pready, pslverr, lo_f, hi_f, qt;
  wire  [11:0] paddr;
  wire  [31:0] pwdata, prdata;
  int          miscompares = 0;
  int          check_count = 0;
  int          cycles = 0;
  logic [32:0] expq[$];
  logic        lo_m = 1'b0;
  logic        hi_m = 1'b0;
  logic [7:0]  s_m = 8'h00;
  logic [7:0]  rng_m = 8'h00;
  logic [7:0]  lo_t = 8'h00;
  logic [7:0]  hi_t = 8'h00;
  int          pct[8] = '{10000, 8002, 6669, 5005, 4005, 3338, 2862, 2504};

  initial
  begin
    forever #2.5 clock = ~clock;
  end

  rxlos_top i_rxlos_top (.clock(clock), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx2_signal_strength(strength), .rx2_signal_lost_low_flag(lo_f),
    .rx2_signal_present_high_flag(hi_f), .rx2_quick_trip_enable(qt));
  rxlos_host u_host (.clock(clock), .pready(pready), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

  task automatic bad(input string m);
    miscompares++;
    $display("CHECK FAILED %0t %s", $time, m);
  endtask

  task automatic conclude();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  always @(posedge clock)
  begin
    cycles++;
    if (psel && penable && pready === 1'b1 && !pwrite)
    begin
      check_count++;
      if (expq.size() == 0)
        bad("unexpected read");
      else if ({pslverr, prdata} !== expq.pop_front())
        bad("read data mismatch");
    end
    if (cycles == 5000)
    begin
      bad("timeout");
      conclude();
    end
  end

  // Hysteresis reference: low wins, otherwise high, otherwise hold
  function automatic void upd();
    if (s_m * 10000 < lo_t * pct[rng_m[2:0]])
      {hi_m, lo_m} = 2'b01;
    else if (s_m * 10000 > hi_t * pct[rng_m[6:4]])
      {hi_m, lo_m} = 2'b10;
  endfunction

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    expq.push_back(e);
    u_host.xfer(1'b0, a, 32'h0);
  endtask

  task automatic st(input logic [7:0] v);
    @(posedge clock);
    strength <= v;
    s_m = v;
    upd();
    repeat (8) @(posedge clock);
    check_count++;
    if ({hi_f, lo_f} !== {hi_m, lo_m})
      bad("alarm pins mismatch");
    rd(12'h810, {17'h0, v, 6'h03, hi_m, lo_m});
  endtask

  initial
  begin
    void'($urandom(32));
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    repeat (2) @(posedge clock);
    for (int i = 0; i < 4; i++)
      rd(12'(12'h2E0 + 4 * i), 33'h0);
    wr(12'h2E0, 32'hFF);
    rng_m = 8'h77;
    rd(12'h6E0, 33'h77);
    wr(12'h2E4, 32'hFF);
    rd(12'h2E4, 33'h0);
    rd(12'h900, 33'h1_0000_0000);
    wr(12'h6E8, 32'hC0);
    hi_t = 8'hC0;
    wr(12'h2EC, 32'h80);
    lo_t = 8'h80;
    upd();
    rd(12'h2E8, 33'hC0);
    for (int k = 0; k < 8; k++)
    begin
      wr(12'h2E0, {25'h0, 3'(k), 1'b0, 3'(k)});
      rng_m = {1'b0, 3'(k), 1'b0, 3'(k)};
      upd();
      st(8'h00);
      st(8'hFF);
      st(8'($urandom));
    end
    wr(12'h80C, 32'h1);
    // The control flop takes the write at the edge the task returns on
    @(posedge clock);
    check_count++;
    if (qt !== 1'b1)
      bad("quick trip pin not set");
    wr(12'h2E8, 32'h11);
    rd(12'h2E8, 33'hC0);
    wr(12'h80C, 32'h2);
    wr(12'h808, 32'h5A);
    wr(12'h2E8, 32'h33);
    hi_t = 8'h33;
    upd();
    rd(12'h2E8, 33'h33);
    wr(12'h80C, 32'h4);
    rd(12'h80C, 33'h2);
    wr(12'h800, 32'h0);
    rd(12'h2E0, 33'h0);
    wr(12'h2E0, 32'h11);
    wr(12'h800, 32'h5A);
    rd(12'h2E0, 33'h77);
    wr(12'h80C, 32'h4);
    wr(12'h800, 32'hFFFFFFFF);
    wr(12'h2E8, 32'h44);
    rd(12'h2E8, 33'h33);
    repeat (3) @(posedge clock);
    conclude();
  end
endmodule
